/* verilog/ext_bus_pkg.sv */
// constants and types for the external bus cycle sequencer
package ext_bus_pkg;
  localparam int ADDR_W    = 24;
  localparam int DATA_W    = 16;
  localparam int NUM_CS    = 4;
  localparam int CS_W      = 2;
  localparam int WIN_LSB   = 16;
  localparam int PLEN_W    = 6;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] AB_BASE = 3'h1;

  typedef struct packed {
    logic [1:0] ab_ext;    // extra setup on window change
    logic       ab_two;    // setup 2 instead of 1
    logic [1:0] cmd;       // command delay
    logic       wsetup;    // write setup / turnaround
    logic [4:0] acc;       // access length minus one
    logic [1:0] hold;      // hold length
    logic       multiplexed_mode;       // multiplexed_mode when set
    logic       rdy_en;    // ready handshake used
    logic       rdy_pol;   // ready active level
    logic       rdy_async; // extra sync stage
  } cs_timing_t;

  typedef struct packed {
    logic [CS_W-1:0]   cs;
    logic              write;
    logic [1:0]        be;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  localparam int REQ_W = $bits(bus_req_t);

  typedef enum logic [2:0] {
    ST_IDLE, ST_AB, ST_CMD, ST_WSET, ST_ACC, ST_HOLD
  } phase_t;
endpackage

/* verilog/req_fifo.sv */
// request fifo with registered full and valid flags
`timescale 1ns/1ps
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk_i,  // system clock
  input  wire logic             reset_n_i,   // async reset
  input  wire logic             in_valid_i,  // write side valid
  output logic                  in_ready_o,  // not full
  input  wire logic [WIDTH-1:0] in_data_i,   // write data
  output logic                  out_valid_o, // not empty
  input  wire logic             out_ready_i, // read side ready
  output logic [WIDTH-1:0]      out_data_o   // head entry
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rptr_r];

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_r[wptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wptr_r      <= '0;
      rptr_r      <= '0;
      count_r     <= '0;
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      logic [AW:0] cnt_nxt;
      cnt_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
      if (push) begin
        wptr_r <= AW'((wptr_r + 1'b1) % DEPTH);
      end
      if (pop) begin
        rptr_r <= AW'((rptr_r + 1'b1) % DEPTH);
      end
      count_r     <= cnt_nxt;
      in_ready_o  <= cnt_nxt != (AW+1)'(DEPTH);
      out_valid_o <= cnt_nxt != '0;
    end
  end
endmodule

/* verilog/ext_bus_seq.sv */
// external bus cycle sequencer: five-phase access engine
// Notes on behaviour
// - every access runs setup, command delay, write setup, access, hold in order, skipping zero-length command delay, write setup and hold
// - phase lengths come per chip select; command delay is 0 to 3 periods
// - address setup is 1 or 2, plus 0 to 3 on window change, at most 5
// - write setup or turnaround phase is 0 or 1 period
// - access is 1 to 32 periods, stretched by ready when enabled
// - hold phase is 0 to 3 periods
// - read data captured on the edge that raises the read strobe
// - address changes after read strobe end do not disturb captured data
// - demultiplexed mode uses 24-bit address bus and separate 16-bit data bus
// - multiplexed mode puts address then data on one shared 16-bit bus
// - drive chip select, latch enable, byte-high enable, read and byte write strobes
// - reference clock out is the system clock itself
// - ready active level is selectable
// - ready inactive at sample inserts a waitstate, active ends the access phase
// - asynchronous ready adds one synchroniser stage
`timescale 1ns/1ps
module ext_bus_seq
  import ext_bus_pkg::*;
#(
  parameter int CS_COUNT = NUM_CS
) (
  input  wire logic                core_clk_i,        // system clock
  input  wire logic                reset_n_i,         // async reset
  input  wire cs_timing_t          timing_cfg_i [CS_COUNT], // chip_select_timing_config
  input  wire logic                req_valid_i,       // request offered
  output logic                     req_ready_o,       // fifo has room
  input  wire bus_req_t            req_i,             // request word
  output logic [DATA_W-1:0]        rdata_o,           // captured read data
  output logic                     rdata_valid_o,     // read done pulse
  output logic                     bus_ref_clock_out_o, // reference clock
  output logic [CS_COUNT-1:0]      cs_n_o,            // chip selects
  output logic                     ale_o,             // address latch enable
  output logic                     byte_high_enable_n_o, // byte_high_enable
  output logic                     rd_n_o,            // read strobe
  output logic                     wrl_n_o,           // low byte write
  output logic                     wrh_n_o,           // high byte write
  output logic [ADDR_W-1:0]        addr_o,            // separate_addr_bus
  output logic [DATA_W-1:0]        ad_o,              // shared_addr_data_bus out
  output logic                     ad_oe_o,           // shared bus enable
  input  wire logic [DATA_W-1:0]   ad_i,              // shared bus in
  output logic [DATA_W-1:0]        data_o,            // separate_data_bus out
  output logic                     data_oe_o,         // data bus enable
  input  wire logic [DATA_W-1:0]   data_i,            // data bus in
  input  wire logic                ready_i            // ready handshake pin
);
  phase_t            state_r;
  phase_t            state_nxt;
  logic [PLEN_W-1:0] cnt_r;
  logic [PLEN_W-1:0] plen_r;
  bus_req_t          cur_r;
  cs_timing_t        cfg_r;
  bus_req_t          nreq;
  cs_timing_t        ncfg;
  logic [2:0]        ab_len_r;
  logic [2:0]        ab_len_new;
  logic [7:0]        last_win_r;
  logic [CS_W-1:0]   last_cs_r;
  logic              fifo_valid;
  bus_req_t          fifo_data;
  logic              start;
  logic              phase_end;
  logic              rdy_act;
  logic [2:0]        rdy_q_r;
  logic              rdy_filt_r;
  logic              rdy_async_r;
  logic [DATA_W-1:0] rd_q1_r;
  logic [DATA_W-1:0] rd_q2_r;
  logic [DATA_W-1:0] rd_q3_r;
  logic [DATA_W-1:0] rd_stable_r;

  req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   (req_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (state_r == ST_IDLE),
    .out_data_o  (fifo_data)
  );

  // clock pin carries the system clock; a flop could only halve it
  assign bus_ref_clock_out_o = core_clk_i;

  // phase following the given one, skipping zero-length phases
  function automatic phase_t next_phase(phase_t p, cs_timing_t c);
    phase_t n;
    n = ST_IDLE;
    case (p)
      ST_AB:   n = (c.cmd != 2'h0) ? ST_CMD : (c.wsetup ? ST_WSET : ST_ACC);
      ST_CMD:  n = c.wsetup ? ST_WSET : ST_ACC;
      ST_WSET: n = ST_ACC;
      ST_ACC:  n = (c.hold != 2'h0) ? ST_HOLD : ST_IDLE;
      default: n = ST_IDLE;
    endcase
    return n;
  endfunction

  // down-counter load value, phase length minus one
  function automatic logic [PLEN_W-1:0] load_val(phase_t p, cs_timing_t c,
                                                 logic [2:0] ab);
    logic [PLEN_W-1:0] v;
    v = '0;
    case (p)
      ST_AB:   v = PLEN_W'(ab) - 1'b1;
      ST_CMD:  v = PLEN_W'(c.cmd) - 1'b1;
      ST_ACC:  v = PLEN_W'(c.acc);
      ST_HOLD: v = PLEN_W'(c.hold) - 1'b1;
      default: v = '0;
    endcase
    return v;
  endfunction

  assign start = (state_r == ST_IDLE) && fifo_valid;
  assign nreq  = (state_r == ST_IDLE) ? fifo_data : cur_r;
  assign ncfg  = (state_r == ST_IDLE) ? timing_cfg_i[fifo_data.cs] : cfg_r;

  // window change stretches setup by the programmed extra periods
  assign ab_len_new = AB_BASE + 3'(ncfg.ab_two) +
    (((fifo_data.addr[ADDR_W-1:WIN_LSB] != last_win_r) ||
      (fifo_data.cs != last_cs_r)) ? 3'(ncfg.ab_ext) : 3'h0);

  // ready level compared against programmed polarity
  assign rdy_act = (cfg_r.rdy_async ? rdy_async_r : rdy_filt_r) == cfg_r.rdy_pol;

  always_comb begin
    phase_end = 1'b0;
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (fifo_valid) begin
          state_nxt = ST_AB;
        end
      end
      ST_AB, ST_CMD, ST_WSET, ST_HOLD: begin
        phase_end = cnt_r == '0;
      end
      ST_ACC: begin
        phase_end = (cnt_r == '0) && (!cfg_r.rdy_en || rdy_act);
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (phase_end) begin
      state_nxt = next_phase(state_r, cfg_r);
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // per-phase down-counter
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= load_val(ST_AB, ncfg, ab_len_new);
    end else if (phase_end) begin
      cnt_r <= load_val(state_nxt, cfg_r, ab_len_r);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // request and timing are frozen for the whole access
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur_r      <= '0;
      cfg_r      <= '0;
      ab_len_r   <= AB_BASE;
      last_win_r <= '0;
      last_cs_r  <= '0;
    end else if (start) begin
      cur_r      <= fifo_data;
      cfg_r      <= ncfg;
      ab_len_r   <= ab_len_new;
      last_win_r <= fifo_data.addr[ADDR_W-1:WIN_LSB];
      last_cs_r  <= fifo_data.cs;
    end
  end

  // ready pin: three stages, level accepted once last two agree
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdy_q_r     <= '0;
      rdy_filt_r  <= 1'b0;
      rdy_async_r <= 1'b0;
    end else begin
      rdy_q_r <= {rdy_q_r[1:0], ready_i};
      if (rdy_q_r[1] == rdy_q_r[2]) begin
        rdy_filt_r <= rdy_q_r[2];
      end
      rdy_async_r <= rdy_filt_r;
    end
  end

  // read data pins, filtered the same way; source picked by bus mode
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_q1_r     <= '0;
      rd_q2_r     <= '0;
      rd_q3_r     <= '0;
      rd_stable_r <= '0;
    end else begin
      rd_q1_r <= cfg_r.multiplexed_mode ? ad_i : data_i;
      rd_q2_r <= rd_q1_r;
      rd_q3_r <= rd_q2_r;
      if (rd_q2_r == rd_q3_r) begin
        rd_stable_r <= rd_q3_r;
      end
    end
  end

  // capture on the edge that ends the access; later address moves are ignored
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o       <= '0;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= 1'b0;
      if (state_r == ST_ACC && phase_end && !cur_r.write) begin
        rdata_o       <= rd_stable_r;
        rdata_valid_o <= 1'b1;
      end
    end
  end

  // control strobes, registered from the next phase
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_n_o  <= '1;
      ale_o   <= 1'b0;
      byte_high_enable_n_o <= 1'b1;
      rd_n_o  <= 1'b1;
      wrl_n_o <= 1'b1;
      wrh_n_o <= 1'b1;
    end else begin
      cs_n_o <= '1;
      if (state_nxt != ST_IDLE) begin
        cs_n_o[nreq.cs] <= 1'b0;
      end
      ale_o   <= state_nxt == ST_AB;
      byte_high_enable_n_o <= !(state_nxt != ST_IDLE && nreq.be[1]);
      rd_n_o  <= !(state_nxt == ST_ACC && !nreq.write);
      wrl_n_o <= !(state_nxt == ST_ACC && nreq.write && nreq.be[0]);
      wrh_n_o <= !(state_nxt == ST_ACC && nreq.write && nreq.be[1]);
    end
  end

  // address and data buses; address is held after the cycle to save toggles
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_o    <= '0;
      ad_o      <= '0;
      ad_oe_o   <= 1'b0;
      data_o    <= '0;
      data_oe_o <= 1'b0;
    end else begin
      ad_oe_o   <= 1'b0;
      data_oe_o <= 1'b0;
      if (state_nxt != ST_IDLE) begin
        addr_o <= nreq.addr;
      end
      if (ncfg.multiplexed_mode) begin
        if (state_nxt == ST_AB || state_nxt == ST_CMD) begin
          ad_o    <= nreq.addr[DATA_W-1:0];
          ad_oe_o <= 1'b1;
        end else if (state_nxt != ST_IDLE && nreq.write) begin
          ad_o    <= nreq.wdata;
          ad_oe_o <= 1'b1;
        end
      end else if (state_nxt inside {ST_WSET, ST_ACC, ST_HOLD} && nreq.write) begin
        data_o    <= nreq.wdata;
        data_oe_o <= 1'b1;
      end
    end
  end

  // cycles spent in the current phase, for checking only
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      plen_r <= '0;
    end else if (state_nxt != state_r) begin
      plen_r <= 6'h01;
    end else if (plen_r != '1) begin
      plen_r <= plen_r + 1'b1;
    end
  end

  sequence leave_s(phase_t p);
    state_r == p && state_nxt != p;
  endsequence

  sequence enter_acc_s;
    state_r == ST_ACC && $past(state_r) != ST_ACC;
  endsequence

  phase_order_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    enter_acc_s |-> $past(state_r) inside {ST_AB, ST_CMD, ST_WSET})
    else $error("access entered from wrong phase");

  cmd_len_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    leave_s(ST_CMD) |-> plen_r == PLEN_W'(cfg_r.cmd) && cfg_r.cmd != 2'h0)
    else $error("command delay length wrong");

  setup_len_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    leave_s(ST_AB) |-> plen_r == PLEN_W'(ab_len_r) && plen_r <= 6'h05)
    else $error("address setup length wrong");

  wset_len_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    leave_s(ST_WSET) |-> plen_r == 6'h01 && cfg_r.wsetup)
    else $error("write setup length wrong");

  acc_len_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    leave_s(ST_ACC) |-> plen_r >= PLEN_W'(cfg_r.acc) + 6'h01 &&
      (cfg_r.rdy_en || plen_r == PLEN_W'(cfg_r.acc) + 6'h01))
    else $error("access length wrong");

  hold_len_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    leave_s(ST_HOLD) |-> plen_r == PLEN_W'(cfg_r.hold))
    else $error("hold length wrong");

  read_capture_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    rdata_valid_o |-> $rose(rd_n_o) && rdata_o == $past(rd_stable_r))
    else $error("read data not taken at strobe end");

  demultiplexed_mode_bus_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_r != ST_IDLE && !cfg_r.multiplexed_mode) |-> !ad_oe_o && addr_o == cur_r.addr)
    else $error("demultiplexed bus misuse");

  mux_addr_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_r == ST_AB && cfg_r.multiplexed_mode) |-> ad_oe_o && ad_o == cur_r.addr[DATA_W-1:0] && !data_oe_o)
    else $error("shared bus lacks address");

  strobe_cs_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!rd_n_o || !wrl_n_o || !wrh_n_o) |-> !cs_n_o[cur_r.cs] && state_r == ST_ACC)
    else $error("strobe outside access");

  ready_wait_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_r == ST_ACC && cnt_r == '0 && cfg_r.rdy_en && !rdy_act) |=> state_r == ST_ACC)
    else $error("waitstate not inserted");

  ready_async_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (leave_s(ST_ACC) and (cfg_r.rdy_en && cfg_r.rdy_async)) |->
      $past(rdy_filt_r) == cfg_r.rdy_pol)
    else $error("async ready not delayed");
endmodule

/* tb/ext_mem_model.sv */
// behavioural external memory with a programmable ready delay
`timescale 1ns/1ps
module ext_mem_model
  import ext_bus_pkg::*;
(
  input  wire logic              core_clk_i, // system clock
  input  wire logic [3:0]        cs_n_i,     // chip selects
  input  wire logic              ale_i,      // latch enable
  input  wire logic              rd_n_i,     // read strobe
  input  wire logic              wrl_n_i,    // low byte write
  input  wire logic              wrh_n_i,    // high byte write
  input  wire logic [ADDR_W-1:0] addr_i,     // separate address bus
  input  wire logic [DATA_W-1:0] ad_out_i,   // shared bus from design
  input  wire logic              ad_oe_i,    // shared bus enable
  input  wire logic [DATA_W-1:0] data_out_i, // data bus from design
  input  wire logic              data_oe_i,  // data bus enable
  input  wire logic              rdy_pol_i,  // ready active level
  input  wire logic [5:0]        rdy_wait_i, // strobe cycles before ready
  output logic [DATA_W-1:0]      ad_o,       // shared bus to design
  output logic [DATA_W-1:0]      data_o,     // data bus to design
  output logic                   ready_o     // ready pin
);
  logic [DATA_W-1:0] mem [16] = '{default: '0};
  logic [3:0]        idx = '0;
  logic [5:0]        cnt = '0;
  logic              sel;
  logic              strobe;
  logic [DATA_W-1:0] wv;
  initial begin
    ad_o = '0;
    data_o = '0;
    ready_o = 1'b0;
  end
  assign sel = ~&cs_n_i;
  assign strobe = ~rd_n_i | ~wrl_n_i | ~wrh_n_i;
  assign wv = data_oe_i ? data_out_i : ad_out_i;
  always @(posedge core_clk_i) begin
    if (ale_i) idx <= ad_oe_i ? ad_out_i[3:0] : addr_i[3:0];
    if (!wrl_n_i) mem[idx][7:0] <= wv[7:0];
    if (!wrh_n_i) mem[idx][15:8] <= wv[15:8];
    // released lines toggle so a stale value can never pass as read data
    data_o <= (sel && !data_oe_i) ? mem[idx] : ~data_o;
    ad_o <= (sel && !ad_oe_i) ? mem[idx] : ~ad_o;
    cnt <= strobe ? cnt + 6'h01 : 6'h00;
    ready_o <= (strobe && cnt >= rdy_wait_i) ? rdy_pol_i : ~rdy_pol_i;
  end
endmodule

/* tb/ext_bus_seq_bench.sv */
// self-checking bench for the external bus cycle sequencer
`timescale 1ns/1ps
module ext_bus_seq_bench;
  import ext_bus_pkg::*;
  logic              core_clk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  cs_timing_t        cfg [4] = '{default: '0};
  logic              req_valid = 1'b0;
  bus_req_t          req = '0;
  logic              rdy_pol = 1'b1;
  logic [5:0]        rdy_wait = 6'h00;
  logic [DATA_W-1:0] rdata, ad_out, ad_in, data_out, data_in;
  logic [ADDR_W-1:0] addr;
  logic [3:0]        cs_n;
  logic              rvalid, ref_clk, ale, hi_en_n, rd_n, wrl_n, wrh_n, ad_oe, data_oe, ready, req_ready;
  logic [7:0]        cnt [9] = '{default: '0};
  logic [7:0]        last [9] = '{default: '0};
  logic [8:0]        cond;
  logic [ADDR_W-1:0] lat_a = '0;
  logic [DATA_W-1:0] lat_ad = '0;
  logic [3:0]        lat_cs = 4'hf;
  logic [DATA_W-1:0] sh [16] = '{default: '0};
  logic              was = 1'b0;
  logic [1:0]        p_cs = 2'd0;
  logic [7:0]        p_win = 8'h00;
  int                done_cnt = 0;
  int                cycles = 0;
  int                fails = 0;
  int                samples_checked = 0;

  always #2 core_clk_i = ~core_clk_i;

  ext_bus_seq DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .timing_cfg_i(cfg), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_i(req), .rdata_o(rdata), .rdata_valid_o(rvalid), .bus_ref_clock_out_o(ref_clk),
    .cs_n_o(cs_n), .ale_o(ale), .byte_high_enable_n_o(hi_en_n), .rd_n_o(rd_n), .wrl_n_o(wrl_n), .wrh_n_o(wrh_n),
    .addr_o(addr), .ad_o(ad_out), .ad_oe_o(ad_oe), .ad_i(ad_in), .data_o(data_out), .data_oe_o(data_oe),
    .data_i(data_in), .ready_i(ready));

  ext_mem_model mem (.core_clk_i(core_clk_i), .cs_n_i(cs_n), .ale_i(ale), .rd_n_i(rd_n), .wrl_n_i(wrl_n),
    .wrh_n_i(wrh_n), .addr_i(addr), .ad_out_i(ad_out), .ad_oe_i(ad_oe), .data_out_i(data_out), .data_oe_i(data_oe),
    .rdy_pol_i(rdy_pol), .rdy_wait_i(rdy_wait), .ad_o(ad_in), .data_o(data_in), .ready_o(ready));

  // per-cycle counts of each bus signal, frozen when chip select ends
  assign cond = {rvalid, data_oe, ad_oe, ~hi_en_n, ~wrh_n, ~wrl_n, ~rd_n | ~wrl_n | ~wrh_n, ale, ~&cs_n};
  always @(posedge core_clk_i) begin
    for (int i = 0; i < 9; i++) begin
      if (cond[0]) cnt[i] <= cnt[i] + 8'(cond[i]);
      else if (was) begin
        last[i] <= cnt[i] + 8'(cond[i]);
        cnt[i] <= 8'h00;
      end
    end
    if (was && !cond[0]) done_cnt <= done_cnt + 1;
    was <= cond[0];
    if (ale) begin
      lat_a <= addr;
      lat_ad <= ad_out;
      lat_cs <= cs_n;
    end
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report;
    end
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wait_done(input int n);
    for (int k = 0; k < 2000 && done_cnt < n; k++) @(posedge core_clk_i);
    check(24'(done_cnt >= n), 24'h1);
  endtask

  function automatic cs_timing_t mk(input logic [1:0] ext, input logic two, input logic [1:0] cmd, input logic ws,
                                    input logic [4:0] acc, input logic [1:0] hold, input logic multiplexed_mode,
                                    input logic [2:0] rdy);
    return '{ext, two, cmd, ws, acc, hold, multiplexed_mode, rdy[2], rdy[1], rdy[0]};
  endfunction

  task automatic set_cfg(input logic [1:0] c, input cs_timing_t v);
    @(posedge core_clk_i);
    cfg[c] <= v;
  endtask

  task automatic acc_run(input logic [1:0] c, input logic w, input logic [1:0] be, input logic [23:0] a,
                         input logic [15:0] wd, output logic [7:0] stb);
    cs_timing_t t;
    logic [7:0] su;
    logic [7:0] body;
    int         n;
    n = done_cnt;
    @(posedge core_clk_i);
    // config written on the previous edge is only visible from here
    t = cfg[c];
    su = 8'(1 + t.ab_two) + (((c != p_cs) || (a[23:16] != p_win)) ? 8'(t.ab_ext) : 8'h00);
    req_valid <= 1'b1;
    req <= '{c, w, be, a, wd};
    @(posedge core_clk_i);
    while (req_ready !== 1'b1) @(posedge core_clk_i);
    req_valid <= 1'b0;
    wait_done(n + 1);
    stb = last[2];
    body = su + t.cmd + t.wsetup + stb + t.hold;
    check(last[1], su);
    if (!t.rdy_en) check(stb, 8'(t.acc) + 8'h01);
    else check(24'(stb > 8'(rdy_wait)), 24'h1);
    check(last[0], body);
    check(last[3], (be[0] && w) ? stb : 8'h00);
    check(last[4], (be[1] && w) ? stb : 8'h00);
    check(last[5], be[1] ? body : 8'h00);
    check(last[6], t.multiplexed_mode ? (w ? body : su + t.cmd) : 8'h00);
    check(last[7], (!t.multiplexed_mode && w) ? body - su - t.cmd : 8'h00);
    if (t.multiplexed_mode) check(lat_ad, a[15:0]);
    else check(lat_a, a);
    check(lat_cs, 4'(~(4'h1 << c)));
    check(last[8], 8'(!w));
    if (!w) check(rdata, sh[a[3:0]]);
    if (w && be[0]) sh[a[3:0]][7:0] = wd[7:0];
    if (w && be[1]) sh[a[3:0]][15:8] = wd[15:8];
    p_cs = c;
    p_win = a[23:16];
  endtask

  task automatic s_reset;
    // reset values settle only after the edge that applies them
    #1;
    check(cs_n, 4'hf);
    check({ale, rd_n, wrl_n, wrh_n, hi_en_n, ad_oe, data_oe, req_ready}, 8'b0111_1000);
    check(ref_clk, core_clk_i);
    #2;
    check(ref_clk, core_clk_i);
  endtask

  task automatic s_phases;
    logic [7:0] s;
    set_cfg(1, mk(2'd2, 1'b1, 2'd2, 1'b1, 5'd7, 2'd2, 1'b0, 3'b000));
    acc_run(1, 1'b1, 2'b11, 24'h12_0003, 16'hbeef, s);
    acc_run(1, 1'b0, 2'b11, 24'h12_0003, 16'h0000, s);
    set_cfg(1, mk(2'd3, 1'b1, 2'd3, 1'b1, 5'd31, 2'd3, 1'b0, 3'b000));
    acc_run(1, 1'b0, 2'b10, 24'h34_0003, 16'h0000, s);
  endtask

  task automatic s_minimal;
    logic [7:0] s;
    set_cfg(0, mk(2'd0, 1'b0, 2'd0, 1'b0, 5'd0, 2'd0, 1'b0, 3'b000));
    acc_run(0, 1'b1, 2'b01, 24'h34_0005, 16'h1122, s);
    acc_run(0, 1'b1, 2'b10, 24'h34_0005, 16'h3344, s);
    set_cfg(0, mk(2'd0, 1'b0, 2'd0, 1'b0, 5'd7, 2'd0, 1'b0, 3'b000));
    acc_run(0, 1'b0, 2'b11, 24'h34_0005, 16'h0000, s);
  endtask

  task automatic s_mux;
    logic [7:0] s;
    set_cfg(2, mk(2'd1, 1'b0, 2'd1, 1'b0, 5'd7, 2'd1, 1'b1, 3'b000));
    acc_run(2, 1'b1, 2'b11, 24'h00_0009, 16'ha55a, s);
    acc_run(2, 1'b0, 2'b11, 24'h00_0009, 16'h0000, s);
    set_cfg(2, mk(2'd1, 1'b1, 2'd0, 1'b1, 5'd31, 2'd3, 1'b1, 3'b000));
    acc_run(2, 1'b0, 2'b01, 24'h00_0009, 16'h0000, s);
  endtask

  task automatic s_ready;
    logic [7:0] s1;
    logic [7:0] s2;
    @(posedge core_clk_i);
    rdy_wait <= 6'd12;
    set_cfg(3, mk(2'd0, 1'b0, 2'd0, 1'b0, 5'd1, 2'd0, 1'b0, 3'b110));
    acc_run(3, 1'b0, 2'b11, 24'h00_0009, 16'h0000, s1);
    set_cfg(3, mk(2'd0, 1'b0, 2'd0, 1'b0, 5'd1, 2'd0, 1'b0, 3'b111));
    acc_run(3, 1'b0, 2'b11, 24'h00_0009, 16'h0000, s2);
    check(24'(s2 > s1), 24'h1);
    @(posedge core_clk_i);
    rdy_pol <= 1'b0;
    set_cfg(3, mk(2'd0, 1'b0, 2'd0, 1'b0, 5'd1, 2'd0, 1'b0, 3'b100));
    acc_run(3, 1'b1, 2'b11, 24'h00_000a, 16'h5678, s1);
  endtask

  task automatic s_fifo;
    logic [7:0] s;
    logic       lo;
    int         i;
    int         n;
    lo = 1'b0;
    i = 0;
    set_cfg(0, mk(2'd0, 1'b0, 2'd0, 1'b0, 5'd31, 2'd0, 1'b0, 3'b000));
    n = done_cnt;
    @(posedge core_clk_i);
    req_valid <= 1'b1;
    req <= '{2'd0, 1'b1, 2'b11, 24'h34_0000, 16'h0000};
    for (int k = 0; k < 300 && i < 6; k++) begin
      @(posedge core_clk_i);
      if (req_ready !== 1'b1) lo = 1'b1;
      else begin
        sh[i] = 16'(i);
        i++;
        req <= '{2'd0, 1'b1, 2'b11, 24'h34_0000 + 24'(i), 16'(i)};
        if (i == 6) req_valid <= 1'b0;
      end
    end
    check(24'(lo), 24'h1);
    wait_done(n + 6);
    check(last[2], 8'd32);
    p_cs = 2'd0;
    p_win = 8'h34;
    set_cfg(0, mk(2'd0, 1'b0, 2'd0, 1'b0, 5'd7, 2'd0, 1'b0, 3'b000));
    acc_run(0, 1'b0, 2'b11, 24'h34_0004, 16'h0000, s);
  endtask

  initial begin
    @(posedge core_clk_i);
    s_reset;
    @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    s_phases;
    s_minimal;
    s_mux;
    s_ready;
    s_fifo;
    final_report;
  end
endmodule
